// >>> logic/dpim_arb_if.sv
// Bank access request and grant signals between controller and arbiter.
`timescale 1ns/1ps
interface dpim_arb_if import dpim_pkg::*; ();
   logic a_valid;
   logic [BANK_W-1:0] a_bank;
   logic b_valid;
   logic [BANK_W-1:0] b_bank;
   logic grant_a;
   logic grant_b;
   logic b_late;
   logic stall;
   modport ctrl(output a_valid, a_bank, b_valid, b_bank,
                input grant_a, grant_b, b_late, stall);
   modport arb(input a_valid, a_bank, b_valid, b_bank,
               output grant_a, grant_b, b_late, stall);
endinterface : dpim_arb_if

// >>> logic/dpim_bank_arb.sv
// Bank arbiter serving two data accesses per cycle, or over two cycles when both address one single-access bank.
`timescale 1ns/1ps
module dpim_bank_arb import dpim_pkg::*; #(
   parameter logic [NUM_BANKS-1:0] DUAL_MASK = DUAL_MASK_RST
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Requests and grants.
   dpim_arb_if.arb bus
);
   logic same_bank;
   logic is_dual;
   logic conflict;
   logic pend_b;

   // ==========================================================
   // Conflict detection.
   // Two accesses meet when both are valid and address one bank.
   assign same_bank = bus.a_valid && bus.b_valid && bus.a_bank == bus.b_bank;
   assign is_dual = DUAL_MASK[bus.a_bank];
   assign conflict = same_bank && !is_dual;

   // A single-access bank serves the first access now, the second next.
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_b <= 1'b0;
      end else begin
         pend_b <= conflict && !pend_b;
      end
   end

   // Grants; a dual bank takes the second access in the late half cycle.
   assign bus.grant_a = bus.a_valid && !pend_b;
   assign bus.grant_b = bus.b_valid && (!conflict || pend_b);
   assign bus.b_late = same_bank && is_dual;
   assign bus.stall = conflict && !pend_b;

   // ==========================================================
   // Checks.
   dual_both_a: assert property (@(posedge clk) disable iff (rst)
      same_bank && is_dual |-> bus.grant_a && bus.grant_b && !bus.stall)
      else $error("dual bank did not take both accesses");
   single_wait_a: assert property (@(posedge clk) disable iff (rst)
      conflict && !pend_b |-> bus.grant_a && !bus.grant_b && bus.stall
      ##1 bus.grant_b && !bus.grant_a && !bus.stall)
      else $error("single bank conflict not served in two cycles");
endmodule : dpim_bank_arb

// >>> logic/dpim_pipe_ctrl.sv
// Pipeline interlock, condition gating and data bus staging of the CPU.
// Contract
// - Data-unit form evaluates its condition in the execute stage.
// - Data-unit form governing a memory write evaluates in read stage.
// - AD-stage modify waits 2 cycles behind an older R-stage test.
// - Register prefetch lets test and modify share one cycle safely.
// - Parallel write pointer post-modification ignores the condition.
// - Address-stage pointer update of conditional load always happens.
// - Governed write happens in write stage only when condition holds.
// - Dual-access bank takes two half-cycle accesses a cycle, no stall.
// - Single-access bank serves one access per cycle; second waits.
// - Coefficient read bus carries 16-bit coefficient from data space.
// - Primary read bus carries one 16-bit value from data or I/O.
// - Second read bus carries second value of dual data reads.
// - Primary write bus carries a 16-bit value to data or I/O.
// - Second write bus carries second value of dual data writes.
// - Address-unit form tests in address stage; gates address to write.
`timescale 1ns/1ps
module dpim_pipe_ctrl import dpim_pkg::*; #(
   parameter logic [NUM_BANKS-1:0] DUAL_MASK = DUAL_MASK_RST
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Instruction issue into decode.
   input wire logic issue_valid,
   input wire dpim_instr_t issue_instr,
   output logic issue_ready,
   // Condition flags of each register, current register file contents.
   input wire logic [NUM_REGS-1:0] cond_flags,
   // Address-stage pointer update and execute-stage operation.
   output logic ptr_upd_en,
   output logic [REG_W-1:0] ptr_upd_reg,
   output logic xop_en,
   output logic [REG_W-1:0] xop_reg,
   // Memory bank accesses.
   input wire logic acc_a_valid,
   input wire logic [BANK_W-1:0] acc_a_bank,
   input wire logic acc_b_valid,
   input wire logic [BANK_W-1:0] acc_b_bank,
   output logic acc_a_grant,
   output logic acc_b_grant,
   output logic acc_b_late,
   // Read buses from memory and their captured values.
   input wire logic [DATA_W-1:0] coef_read_bus,
   input wire logic [DATA_W-1:0] primary_read_bus,
   input wire logic [DATA_W-1:0] second_read_bus,
   output logic [DATA_W-1:0] coef_data,
   output logic [DATA_W-1:0] primary_data,
   output logic [DATA_W-1:0] second_data,
   output logic coef_valid,
   output logic primary_valid,
   output logic second_valid,
   // Write data from the CPU and the write buses to memory.
   input wire logic [DATA_W-1:0] wr_data_a,
   input wire logic [DATA_W-1:0] wr_data_b,
   output logic [DATA_W-1:0] primary_write_bus,
   output logic [DATA_W-1:0] second_write_bus,
   output logic primary_wr_en,
   output logic second_wr_en,
   // Status.
   output logic hazard_stall,
   output logic mem_stall
);
   logic [NUM_STAGES-1:0] stg_valid;
   dpim_instr_t stg_ins [NUM_STAGES];
   logic [NUM_STAGES-1:0] stg_ok;
   logic [NUM_STAGES-1:0] pass_now;
   logic [NUM_STAGES-1:0] gate_ok;
   logic haz_rbw;
   logic haz_wbr;
   logic r_flag;
   logic ad_flag;

   dpim_arb_if arb_bus ();

   // ==========================================================
   // Bank arbitration.
   // Requests go to the arbiter; a single bank conflict freezes the pipe.
   assign arb_bus.a_valid = acc_a_valid;
   assign arb_bus.a_bank = acc_a_bank;
   assign arb_bus.b_valid = acc_b_valid;
   assign arb_bus.b_bank = acc_b_bank;
   assign acc_a_grant = arb_bus.grant_a;
   assign acc_b_grant = arb_bus.grant_b;
   assign acc_b_late = arb_bus.b_late;
   assign mem_stall = arb_bus.stall;

   dpim_bank_arb #(.DUAL_MASK(DUAL_MASK)) u_arb (
      .clk(clk),
      .rst(rst),
      .bus(arb_bus.arb)
   );

   // ==========================================================
   // Condition evaluation.
   // Each stage knows whether its condition passes and whether it gates.
   always_comb begin
      for (int s = 0; s < NUM_STAGES; s++) begin
         if (stg_ins[s].cond_mode == DPIM_COND_NONE) begin
            pass_now[s] = 1'b1;
         end else if (3'(s) == dpim_eval_stage(stg_ins[s])) begin
            pass_now[s] = cond_flags[stg_ins[s].test_reg];
         end else begin
            pass_now[s] = stg_ok[s];
         end
         // Stages before the evaluation stage run unconditionally.
         if (stg_ins[s].cond_mode == DPIM_COND_NONE ||
             3'(s) < dpim_eval_stage(stg_ins[s])) begin
            gate_ok[s] = 1'b1;
         end else begin
            gate_ok[s] = pass_now[s];
         end
      end
   end

   // ==========================================================
   // Interlock.
   // The decode instruction is compared against each older one in address through execute stage.
   always_comb begin
      haz_rbw = 1'b0;
      haz_wbr = 1'b0;
      for (int s = 1; s < NUM_STAGES - 1; s++) begin
         // A modify in address stage may not overtake an older test;
         // it may land in the very cycle of the test thanks to prefetch.
         if (stg_ins[0].mod_en && stg_valid[s] &&
             stg_ins[s].cond_mode != DPIM_COND_NONE &&
             stg_ins[s].test_reg == stg_ins[0].mod_reg &&
             3'(s + 1) < dpim_eval_stage(stg_ins[s])) begin
            haz_rbw = 1'b1;
         end
         // A test must see the result of an older execute-stage write.
         if (stg_ins[0].cond_mode != DPIM_COND_NONE && stg_valid[s] &&
             stg_ins[s].xwr_en &&
             stg_ins[s].xwr_reg == stg_ins[0].test_reg &&
             4'(s) + 4'(dpim_eval_stage(stg_ins[0])) < 4'(ST_W)) begin
            haz_wbr = 1'b1;
         end
      end
   end

   assign hazard_stall = stg_valid[0] && (haz_rbw || haz_wbr);
   assign issue_ready = !mem_stall && !hazard_stall;

   // ==========================================================
   // Pipeline stages.
   // Stages advance together; a hazard inserts a bubble behind decode.
   always_ff @(posedge clk) begin
      if (rst) begin
         stg_valid <= '0;
         stg_ok <= '1;
         for (int s = 0; s < NUM_STAGES; s++) begin
            stg_ins[s] <= '{cond_mode: DPIM_COND_NONE, default: '0};
         end
      end else if (!mem_stall) begin
         for (int s = NUM_STAGES - 1; s > 1; s--) begin
            stg_valid[s] <= stg_valid[s-1];
            stg_ins[s] <= stg_ins[s-1];
            stg_ok[s] <= pass_now[s-1];
         end
         stg_valid[1] <= stg_valid[0] && !hazard_stall;
         stg_ins[1] <= stg_ins[0];
         stg_ok[1] <= 1'b1;
         if (!hazard_stall) begin
            stg_valid[0] <= issue_valid;
            stg_ins[0] <= issue_instr;
         end
      end
   end

   // Address-stage and execute-stage operations fire once, on advance.
   assign ptr_upd_en = stg_valid[ST_AD] && stg_ins[ST_AD].mod_en &&
                       gate_ok[ST_AD] && !mem_stall;
   assign ptr_upd_reg = stg_ins[ST_AD].mod_reg;
   assign xop_en = stg_valid[ST_X] && gate_ok[ST_X] && !mem_stall;
   assign xop_reg = stg_ins[ST_X].xwr_reg;

   // ==========================================================
   // Read buses.
   // Values on the read buses are captured in read stage when not gated.
   always_ff @(posedge clk) begin
      if (rst) begin
         coef_valid <= 1'b0;
         primary_valid <= 1'b0;
         second_valid <= 1'b0;
         coef_data <= '0;
         primary_data <= '0;
         second_data <= '0;
      end else begin
         coef_valid <= 1'b0;
         primary_valid <= 1'b0;
         second_valid <= 1'b0;
         if (stg_valid[ST_R] && gate_ok[ST_R] && !mem_stall) begin
            if (stg_ins[ST_R].rd_coef) begin
               coef_valid <= 1'b1;
               coef_data <= coef_read_bus;
            end
            if (stg_ins[ST_R].rd_primary) begin
               primary_valid <= 1'b1;
               primary_data <= primary_read_bus;
            end
            if (stg_ins[ST_R].rd_second) begin
               second_valid <= 1'b1;
               second_data <= second_read_bus;
            end
         end
      end
   end

   // ==========================================================
   // Write buses.
   // A write is staged on entry to write stage and dropped if it fails.
   always_ff @(posedge clk) begin
      if (rst) begin
         primary_wr_en <= 1'b0;
         second_wr_en <= 1'b0;
         primary_write_bus <= '0;
         second_write_bus <= '0;
      end else begin
         primary_wr_en <= 1'b0;
         second_wr_en <= 1'b0;
         if (stg_valid[ST_X] && stg_ins[ST_X].mem_wr && gate_ok[ST_X] &&
             !mem_stall) begin
            primary_wr_en <= 1'b1;
            primary_write_bus <= wr_data_a;
            if (stg_ins[ST_X].wr_dual) begin
               second_wr_en <= 1'b1;
               second_write_bus <= wr_data_b;
            end
         end
      end
   end

   // ==========================================================
   // Checks.
   assign r_flag = cond_flags[stg_ins[ST_R].test_reg];
   assign ad_flag = cond_flags[stg_ins[ST_AD].test_reg];

   default clocking pipe_clk @(posedge clk); endclocking
   default disable iff (rst);

   x_eval_a: assert property (
      stg_valid[ST_X] && stg_ins[ST_X].cond_mode == DPIM_COND_D &&
      !stg_ins[ST_X].mem_wr && !mem_stall |->
      xop_en == cond_flags[stg_ins[ST_X].test_reg])
      else $error("execute stage condition misapplied");
   r_eval_a: assert property (
      stg_valid[ST_R] && stg_ins[ST_R].cond_mode == DPIM_COND_D &&
      stg_ins[ST_R].mem_wr && !mem_stall |=> stg_ok[ST_X] == $past(r_flag))
      else $error("read stage condition not latched");
   rbw_stall_a: assert property (
      haz_rbw && stg_valid[0] && !mem_stall |-> !issue_ready
      ##1 !stg_valid[ST_AD])
      else $error("modify overtook older test");
   prefetch_a: assert property (
      ptr_upd_en && stg_valid[ST_R] && stg_ins[ST_R].mem_wr &&
      stg_ins[ST_R].cond_mode == DPIM_COND_D &&
      stg_ins[ST_R].test_reg == ptr_upd_reg |=>
      stg_ok[ST_X] == $past(r_flag))
      else $error("test did not use prefetched value");
   ptr_uncond_a: assert property (
      stg_valid[ST_AD] && stg_ins[ST_AD].cond_mode == DPIM_COND_D &&
      stg_ins[ST_AD].mod_en && !mem_stall |-> ptr_upd_en)
      else $error("pointer update wrongly gated");
   wr_gate_a: assert property (
      primary_wr_en |-> stg_valid[ST_W] && stg_ok[ST_W])
      else $error("memory write despite failed condition");
   read_cap_a: assert property (
      stg_valid[ST_R] && stg_ins[ST_R].rd_primary && gate_ok[ST_R] &&
      !mem_stall |=> primary_valid && primary_data == $past(primary_read_bus))
      else $error("primary read value not captured");
   wr_bus_a: assert property (
      stg_valid[ST_X] && stg_ins[ST_X].mem_wr && stg_ins[ST_X].wr_dual &&
      gate_ok[ST_X] && !mem_stall |=> second_wr_en &&
      second_write_bus == $past(wr_data_b))
      else $error("second write value not driven");
   ad_gate_a: assert property (
      stg_valid[ST_AD] && stg_ins[ST_AD].cond_mode == DPIM_COND_AD &&
      stg_ins[ST_AD].mod_en && !mem_stall |-> ptr_upd_en == ad_flag)
      else $error("address unit condition misapplied");
   wbr_stall_a: assert property (
      haz_wbr && stg_valid[0] && !mem_stall |=> $stable(stg_ins[0]))
      else $error("test moved ahead of pending write");
endmodule : dpim_pipe_ctrl

// >>> logic/dpim_pkg.sv
// Shared constants and types of the pipeline interlock and memory bus block.
package dpim_pkg;
   // ==========================================================
   // Pipeline stages, indexed from decode to write.
   localparam int NUM_STAGES = 7;
   localparam logic [2:0] ST_D = 3'h0;
   localparam logic [2:0] ST_AD = 3'h1;
   localparam logic [2:0] ST_ADR1 = 3'h2;
   localparam logic [2:0] ST_ADR2 = 3'h3;
   localparam logic [2:0] ST_R = 3'h4;
   localparam logic [2:0] ST_X = 3'h5;
   localparam logic [2:0] ST_W = 3'h6;

   // ==========================================================
   // Widths of data, register indices and bank indices.
   localparam int DATA_W = 16;
   localparam int REG_W = 3;
   localparam int NUM_REGS = 8;
   localparam int BANK_W = 3;
   localparam int NUM_BANKS = 8;
   // Banks that are dual-access; all other banks are single-access.
   localparam logic [7:0] DUAL_MASK_RST = 8'h0F;

   // ==========================================================
   // Conditional forms of an instruction.
   typedef enum logic [2:0] {
      DPIM_COND_NONE = 3'h1,
      DPIM_COND_AD = 3'h2,
      DPIM_COND_D = 3'h4
   } dpim_cond_t;

   // Decoded instruction as it travels down the pipeline.
   typedef struct packed {
      dpim_cond_t cond_mode;
      logic [REG_W-1:0] test_reg;
      logic mem_wr;
      logic wr_dual;
      logic mod_en;
      logic [REG_W-1:0] mod_reg;
      logic xwr_en;
      logic [REG_W-1:0] xwr_reg;
      logic rd_coef;
      logic rd_primary;
      logic rd_second;
   } dpim_instr_t;

   // Stage in which the condition of an instruction is evaluated.
   function automatic logic [2:0] dpim_eval_stage(input dpim_instr_t ins);
      if (ins.cond_mode == DPIM_COND_AD) begin
         return ST_AD;
      end else if (ins.cond_mode == DPIM_COND_D) begin
         return ins.mem_wr ? ST_R : ST_X;
      end
      return ST_D;
   endfunction : dpim_eval_stage
endpackage : dpim_pkg

// >>> testbench/dpim_mem_model.sv
// Partner model of the data memory banks behind the CPU buses.
`timescale 1ns/1ps
module dpim_mem_model import dpim_pkg::*; (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Read slot from the bench and the word stored there.
   input wire logic rd_en,
   input wire logic [DATA_W-1:0] rd_word,
   // Read buses toward the CPU.
   output logic [DATA_W-1:0] coef_read_bus,
   output logic [DATA_W-1:0] primary_read_bus,
   output logic [DATA_W-1:0] second_read_bus,
   // Write buses from the CPU and what was stored.
   input wire logic [DATA_W-1:0] primary_write_bus,
   input wire logic [DATA_W-1:0] second_write_bus,
   input wire logic primary_wr_en,
   input wire logic second_wr_en,
   output logic [DATA_W-1:0] last_a,
   output logic [DATA_W-1:0] last_b,
   output logic [7:0] wr_count
);
   // ==========================================================
   // Read side.
   logic [DATA_W-1:0] junk;
   // Idle buses carry a pattern that flips every cycle.
   always_ff @(posedge clk) begin
      junk <= rst ? 16'hA5C3 : ~junk;
   end
   // Each bus shows its word only inside the read slot.
   assign coef_read_bus = rd_en ? rd_word ^ 16'h0F0F : junk;
   assign primary_read_bus = rd_en ? rd_word : ~junk;
   assign second_read_bus = rd_en ? rd_word + 16'h0001
                                  : junk ^ 16'h00FF;
   // ==========================================================
   // Write side.
   // Stores each write pulse and counts the words taken.
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_count <= 8'h00;
         last_a <= 16'h0000;
         last_b <= 16'h0000;
      end else begin
         if (primary_wr_en) begin
            last_a <= primary_write_bus;
         end
         if (second_wr_en) begin
            last_b <= second_write_bus;
         end
         wr_count <= wr_count + 8'(primary_wr_en) + 8'(second_wr_en);
      end
   end
endmodule : dpim_mem_model

// >>> testbench/test_dsp_pipeline_interlock_membus.sv
// Self-checking bench of the pipeline interlock and memory bus block.
`timescale 1ns/1ps
module test_dsp_pipeline_interlock_membus import dpim_pkg::*; ;
   // ==========================================================
   // Signals and instances.
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic issue_valid, issue_ready, mem_rd, ptr_upd_en, xop_en;
   logic acc_a_valid, acc_b_valid, acc_a_grant, acc_b_grant, acc_b_late;
   logic coef_valid, primary_valid, second_valid, primary_wr_en;
   logic second_wr_en, hazard_stall, mem_stall;
   dpim_instr_t issue_instr;
   logic [NUM_REGS-1:0] cond_flags;
   logic [REG_W-1:0] ptr_upd_reg, xop_reg;
   logic [BANK_W-1:0] acc_a_bank, acc_b_bank;
   logic [DATA_W-1:0] coef_read_bus, primary_read_bus, second_read_bus;
   logic [DATA_W-1:0] coef_data, primary_data, second_data, wr_data_a;
   logic [DATA_W-1:0] wr_data_b, primary_write_bus, second_write_bus;
   logic [DATA_W-1:0] last_a, last_b;
   logic [7:0] wr_count;
   logic [15:0] pu, xo, pv, wa, wb, hs;
   logic [2:0] pr [16];
   logic [7:0] fl [16];
   int errors, num_checks;

   // The clock flips every half period of 2.5 ns.
   always #2.5 clk = ~clk;

   dpim_pipe_ctrl uut (
      .clk, .rst, .issue_valid, .issue_instr, .issue_ready, .cond_flags,
      .ptr_upd_en, .ptr_upd_reg, .xop_en, .xop_reg, .acc_a_valid,
      .acc_a_bank, .acc_b_valid, .acc_b_bank, .acc_a_grant, .acc_b_grant,
      .acc_b_late, .coef_read_bus, .primary_read_bus, .second_read_bus,
      .coef_data, .primary_data, .second_data, .coef_valid, .primary_valid,
      .second_valid, .wr_data_a, .wr_data_b, .primary_write_bus,
      .second_write_bus, .primary_wr_en, .second_wr_en, .hazard_stall,
      .mem_stall
   );
   dpim_mem_model mem (
      .clk, .rst, .rd_en(mem_rd), .rd_word(16'h1234), .coef_read_bus,
      .primary_read_bus, .second_read_bus, .primary_write_bus,
      .second_write_bus, .primary_wr_en, .second_wr_en, .last_a, .last_b,
      .wr_count
   );

   // ==========================================================
   // Helpers.
   function automatic dpim_instr_t mk(input dpim_cond_t c,
      input logic [2:0] t, input logic [3:0] f, input logic [2:0] m,
      input logic [2:0] x, input logic [2:0] rd);
      return dpim_instr_t'({c, t, f[3:1], m, f[0], x, rd});
   endfunction : mk

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   // Flag mask m is true at cycle at only, or everywhere else when inv.
   task automatic fill(input logic [7:0] m, input int at, input bit inv);
      for (int k = 0; k < 16; k++) begin
         fl[k] = ((k == at) != inv) ? m : 8'h00;
      end
   endtask : fill

   // Issues i0, then, when two is set, offers i1 until taken, recording outputs per cycle.
   task automatic run_seq(input dpim_instr_t i0, input dpim_instr_t i1,
                          input logic two);
      logic pend;
      pend = two;
      issue_valid = 1'b1;
      issue_instr = i0;
      // The first instruction enters decode at this edge, so cycle 0 of
      // the record is its decode cycle and cycle 1 its address stage.
      @(posedge clk);
      #1;
      issue_valid = pend;
      issue_instr = i1;
      for (int k = 0; k < 16; k++) begin
         cond_flags = fl[k];
         mem_rd = (k == 4);
         @(negedge clk);
         {pu[k], xo[k], pv[k], wa[k], wb[k], hs[k]} = {ptr_upd_en, xop_en,
            primary_valid, primary_wr_en, second_wr_en, hazard_stall};
         pr[k] = ptr_upd_reg;
         if (issue_ready === 1'b1) begin
            pend = 1'b0;
         end
         @(posedge clk);
         #1;
         issue_valid = pend;
         issue_instr = i1;
      end
   endtask : run_seq

   // ==========================================================
   // Scenarios.
   // Data-unit form without a write: execute-stage gate, reads ungated.
   task automatic s_d_exec;
      dpim_instr_t ins;
      ins = mk(DPIM_COND_D, 3'h2, 4'b0011, 3'h1, 3'h4, 3'b111);
      for (int r = 0; r < 2; r++) begin
         fill(8'h04, 5, r == 1);
         run_seq(ins, ins, 1'b0);
         check("xop_en", xo, r == 0 ? 16'h0020 : 16'h0000);
         check("ptr_upd", pu, 16'h0002);
         check("rd_valid", pv, 16'h0020);
         check("primary", primary_data, 16'h1234);
         check("coef", coef_data, 16'h1D3B);
         check("second", second_data, 16'h1235);
      end
      check("xop_reg", {13'h0000, xop_reg}, 16'h0004);
   endtask : s_d_exec

   // Data-unit form governing a dual write: read-stage gate.
   task automatic s_d_write;
      dpim_instr_t ins;
      ins = mk(DPIM_COND_D, 3'h3, 4'b1110, 3'h1, 3'h0, 3'b000);
      wr_data_a = 16'hA001;
      wr_data_b = 16'hB002;
      for (int r = 0; r < 2; r++) begin
         fill(8'h08, 4, r == 1);
         run_seq(ins, ins, 1'b0);
         check("wr_a", wa, r == 0 ? 16'h0040 : 16'h0000);
         check("wr_b", wb, r == 0 ? 16'h0040 : 16'h0000);
         check("ptr_upd", pu, 16'h0002);
         check("wr_count", {8'h00, wr_count}, 16'h0002);
      end
      check("last_a", last_a, 16'hA001);
      check("last_b", last_b, 16'hB002);
   endtask : s_d_write

   // Address-unit form: one test in the address stage gates everything.
   task automatic s_ad_mode;
      dpim_instr_t ins;
      ins = mk(DPIM_COND_AD, 3'h6, 4'b1011, 3'h5, 3'h7, 3'b010);
      for (int r = 0; r < 2; r++) begin
         fill(8'h40, 1, r == 1);
         run_seq(ins, ins, 1'b0);
         check("ad_ptr", pu, r == 0 ? 16'h0002 : 16'h0000);
         check("ad_xop", xo, r == 0 ? 16'h0020 : 16'h0000);
         check("ad_rd", pv, r == 0 ? 16'h0020 : 16'h0000);
         check("ad_wr", wa, r == 0 ? 16'h0040 : 16'h0000);
      end
   endtask : s_ad_mode

   // Read-stage test followed at once by an address-stage modify.
   task automatic s_interlock;
      fill(8'h08, 4, 1'b0);
      run_seq(mk(DPIM_COND_D, 3'h3, 4'b1010, 3'h1, 3'h0, 3'h0),
              mk(DPIM_COND_NONE, 3'h0, 4'b0010, 3'h3, 3'h0, 3'h0), 1'b1);
      check("stall", hs, 16'h0006);
      check("ptr_upd", pu, 16'h0012);
      check("upd_reg", {13'h0000, pr[4]}, 16'h0003);
      check("test_wr", wa, 16'h0040);
   endtask : s_interlock

   // Address-stage test of a register still written by an older one.
   task automatic s_ad_hazard;
      fill(8'h01, 0, 1'b1);
      run_seq(mk(DPIM_COND_NONE, 3'h0, 4'b0001, 3'h0, 3'h0, 3'h0),
              mk(DPIM_COND_AD, 3'h0, 4'b0010, 3'h2, 3'h0, 3'h0), 1'b1);
      check("stall", hs, 16'h001E);
      check("ptr_upd", pu, 16'h0040);
      check("xop_en", xo, 16'h0420);
   endtask : s_ad_hazard

   // Two accesses to a dual bank, then to a single bank.
   task automatic s_banks;
      {acc_a_valid, acc_b_valid, acc_a_bank, acc_b_bank} = {2'b11, 6'o22};
      @(negedge clk);
      check("dual", {11'h000, acc_a_grant, acc_b_grant, acc_b_late,
            mem_stall, issue_ready}, 16'h001D);
      @(posedge clk);
      #1;
      {acc_a_bank, acc_b_bank} = 6'o55;
      @(negedge clk);
      check("single1", {11'h000, acc_a_grant, acc_b_grant, acc_b_late,
            mem_stall, issue_ready}, 16'h0012);
      @(posedge clk);
      @(negedge clk);
      check("single2", {11'h000, acc_a_grant, acc_b_grant, acc_b_late,
            mem_stall, issue_ready}, 16'h0009);
      @(posedge clk);
      #1;
      {acc_a_valid, acc_b_valid} = 2'b00;
   endtask : s_banks

   // ==========================================================
   // Main sequence and watchdog.
   initial begin
      {issue_valid, mem_rd, acc_a_valid, acc_b_valid} = 4'h0;
      {acc_a_bank, acc_b_bank, cond_flags} = 14'h0000;
      {wr_data_a, wr_data_b} = 32'h0000_0000;
      issue_instr = mk(DPIM_COND_NONE, 3'h0, 4'h0, 3'h0, 3'h0, 3'h0);
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      @(negedge clk);
      check("reset", {8'h00, primary_valid, coef_valid, second_valid,
            primary_wr_en, second_wr_en, hazard_stall, mem_stall,
            ptr_upd_en}, 16'h0000);
      @(posedge clk);
      #1;
      s_d_exec();
      s_d_write();
      s_ad_mode();
      s_interlock();
      s_ad_hazard();
      s_banks();
      complete_run();
   end

   // Cuts a hang short well beyond the expected run time.
   initial begin
      #5000;
      errors++;
      complete_run();
   end
endmodule : test_dsp_pipeline_interlock_membus
